//--- kr4_reconf_pkg.sv
package kr4_reconf_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int LANES  = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] LAUNCH_ADDR  = 12'h000;
    localparam logic [11:0] PCS_SEL_ADDR = 12'h004;
    localparam logic [11:0] DFE_ADDR     = 12'h008;
    localparam logic [11:0] CTLE_ADDR    = 12'h00C;
    localparam logic [11:0] STATUS_ADDR  = 12'h010;
    localparam logic [11:0] TRAINED_IDX  = 12'h0D2;
    localparam logic [11:0] TRAINED_ADDR = {TRAINED_IDX[9:0], 2'h0};

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int LAUNCH_KIND_LSB = 4;
    localparam int STAT_BUSY_LSB   = 4;
    localparam int STAT_RXEQ_LSB   = 8;
    localparam int STAT_MIF_BIT    = 12;
    localparam int TRAINED_STRIDE  = 8;
    localparam int DFE_FIELD_W     = 2;
    localparam int CTLE_FIELD_W    = 4;
    localparam logic [1:0]  PCS_SEL_RST  = 2'h0;
    localparam logic [7:0]  DFE_CFG_RST  = 8'h00;
    localparam logic [15:0] CTLE_CFG_RST = 16'h0000;

    // ---------------------------------------------------------------
    // encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_NONE = 2'b00,
        KIND_PCS  = 2'b01,
        KIND_DFE  = 2'b10,
        KIND_CTLE = 2'b11
    } req_kind_e;

    typedef enum logic [1:0] {
        LANE_IDLE = 2'b00,
        LANE_REQ  = 2'b01,
        LANE_HOLD = 2'b10
    } lane_state_e;

    localparam logic [1:0] SEL_AN   = 2'h0;
    localparam logic [1:0] SEL_LT   = 2'h1;
    localparam logic [1:0] SEL_DATA = 2'h2;
    localparam logic [5:0] PCS_AN   = 6'h01;
    localparam logic [5:0] PCS_LT   = 6'h02;
    localparam logic [5:0] PCS_DATA = 6'h20;
    localparam logic [1:0] DFE_OFF  = 2'h0;
    localparam logic [1:0] DFE_ONCE = 2'h1;
    localparam logic [1:0] CTLE_MODE_VAL = 2'h0;

    // reserved dfe codes fall back to disabled
    function automatic logic [1:0] dfe_legal(input logic [1:0] code);
        dfe_legal = (code == DFE_ONCE) ? DFE_ONCE : DFE_OFF;
    endfunction

    function automatic logic [5:0] pcs_onehot(input logic [1:0] sel);
        case (sel)
            SEL_LT:   pcs_onehot = PCS_LT;
            SEL_DATA: pcs_onehot = PCS_DATA;
            default:  pcs_onehot = PCS_AN;
        endcase
    endfunction

endpackage

//--- lane_reconf_ctrl.sv
module lane_reconf_ctrl
    import kr4_reconf_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // request from the register side
    input  wire logic       launch,
    input  wire req_kind_e  kind,
    input  wire logic       abort,
    input  wire logic [1:0] dfe_in,
    input  wire logic [3:0] ctle_in,
    // synchronised partner busy
    input  wire logic       busy,
    // toward the partner
    output wire logic       pcs_go,
    output wire logic       dfe_go,
    output wire logic       ctle_go,
    output wire logic [1:0] dfe_mode,
    output wire logic [3:0] ctle_value,
    output wire logic       active
);

    typedef struct packed {
        lane_state_e st;
        logic        pcs_go;
        logic        dfe_go;
        logic        ctle_go;
        logic [1:0]  dfe;
        logic [3:0]  ctle;
    } lane_s;

    lane_s lane_reg;
    lane_s lane_next;

    always_comb begin
        lane_next = lane_reg;
        if (abort) begin
            lane_next.st      = LANE_IDLE;
            lane_next.pcs_go  = 1'b0;
            lane_next.dfe_go  = 1'b0;
            lane_next.ctle_go = 1'b0;
        end else begin
            case (lane_reg.st)
                LANE_IDLE: begin
                    // no new request while the partner still works on the lane
                    if (launch && !busy && kind != KIND_NONE) begin
                        lane_next.st      = LANE_REQ;
                        lane_next.pcs_go  = (kind == KIND_PCS);
                        lane_next.dfe_go  = (kind == KIND_DFE);
                        lane_next.ctle_go = (kind == KIND_CTLE);
                        if (kind == KIND_DFE) begin
                            lane_next.dfe = dfe_legal(dfe_in);
                        end
                        if (kind == KIND_CTLE) begin
                            lane_next.ctle = ctle_in;
                        end
                    end
                end
                LANE_REQ: begin
                    // start stays up until busy is seen
                    if (busy) begin
                        lane_next.st      = LANE_HOLD;
                        lane_next.pcs_go  = 1'b0;
                        lane_next.dfe_go  = 1'b0;
                        lane_next.ctle_go = 1'b0;
                    end
                end
                LANE_HOLD: begin
                    if (!busy) begin
                        lane_next.st = LANE_IDLE;
                    end
                end
                default: begin
                    lane_next.st = LANE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_reg <= '{st: LANE_IDLE, pcs_go: 1'b0, dfe_go: 1'b0, ctle_go: 1'b0,
                          dfe: DFE_OFF, ctle: 4'h0};
        end else begin
            lane_reg <= lane_next;
        end
    end

    assign pcs_go     = lane_reg.pcs_go;
    assign dfe_go     = lane_reg.dfe_go;
    assign ctle_go    = lane_reg.ctle_go;
    assign dfe_mode   = lane_reg.dfe;
    assign ctle_value = lane_reg.ctle;
    assign active     = (lane_reg.st != LANE_IDLE);

endmodule

//--- kr4_lane_reconf.sv
// Overview of operation
// - Each four-lane vector is cut into four equal fields, lane 0 lowest, lane 3 highest.
// - A lane's PCS start bit asks the partner to reconfigure that lane's PCS.
// - A lane's DFE start bit launches RX decision-feedback equalization on that lane.
// - Each DFE mode field is 00 (off) or 01 (single shot); 10 and 11 are never driven.
// - The DFE mode field is valid when the DFE start rises and holds until busy falls.
// - A lane's CTLE start bit requests linear equalizer reconfiguration on that lane.
// - Each CTLE value runs from 0000 (off) to 1111 (maximum).
// - CTLE value and CTLE mode are valid when the CTLE start rises and hold until busy falls.
// - Every CTLE mode field is always driven to zero.
// - The PCS mode request is one-hot: 000001 AN, 000010 LT, 100000 data, nothing else.
// - The custom RX equalization enable mirrors the link-trained bits 0, 8, 16, 24.
// - A lane counts as trained only when its done bit and its internal trained flag hold.
module kr4_lane_reconf
    import kr4_reconf_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    // from the reconfiguration partner
    input  wire logic [3:0]  reconf_in_progress,
    input  wire logic [3:0]  rxeq_done,
    input  wire logic        mif_done,
    // from internal link training
    input  wire logic [3:0]  rx_trained_lt,
    // toward the reconfiguration partner
    output wire logic [3:0]  pcs_reconf_go,
    output wire logic [5:0]  pcs_mode_request,
    output wire logic [3:0]  decision_eq_go,
    output wire logic [7:0]  decision_eq_mode,
    output wire logic [3:0]  linear_eq_go,
    output wire logic [15:0] linear_eq_value,
    output wire logic [7:0]  linear_eq_mode,
    output wire logic [3:0]  custom_rxeq_en
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  busy_m;
        logic [3:0]  busy_s;
        logic [3:0]  rxeq_m;
        logic [3:0]  rxeq_s;
        logic        mif_m;
        logic        mif_s;
        logic        mif_d;
        logic [1:0]  pcs_sel;
        logic [7:0]  dfe_cfg;
        logic [15:0] ctle_cfg;
        logic [5:0]  pcs_mode;
        logic [3:0]  trained;
        logic [7:0]  ctle_mode;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } top_s;

    top_s top_reg;
    top_s top_next;

    // one clock domain: every check below, lanes included, samples on pclk
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [3:0] lane_active;
    logic       wr_acc;
    logic       setup;
    logic       launch_wr;
    logic       abort;
    req_kind_e  launch_kind;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == LAUNCH_ADDR) || (a == PCS_SEL_ADDR) || (a == DFE_ADDR) ||
                 (a == CTLE_ADDR) || (a == STATUS_ADDR) || (a == TRAINED_ADDR);
    endfunction

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    assign setup       = psel && !penable;
    assign wr_acc      = psel && penable && pwrite && top_reg.ready;
    assign launch_wr   = wr_acc && (paddr == LAUNCH_ADDR);
    assign launch_kind = req_kind_e'(pwdata[LAUNCH_KIND_LSB +: 2]);
    // mif load complete cancels every open lane handshake
    assign abort       = top_reg.mif_s && !top_reg.mif_d;

    always_comb begin
        top_next = top_reg;
        // partner inputs cross in through two flops
        top_next.busy_m = reconf_in_progress;
        top_next.busy_s = top_reg.busy_m;
        top_next.rxeq_m = rxeq_done;
        top_next.rxeq_s = top_reg.rxeq_m;
        top_next.mif_m  = mif_done;
        top_next.mif_s  = top_reg.mif_m;
        top_next.mif_d  = top_reg.mif_s;

        top_next.trained   = top_reg.rxeq_s & rx_trained_lt;
        top_next.ctle_mode = {LANES{CTLE_MODE_VAL}};
        // mode only moves while no lane handshake is open
        if (lane_active == 4'h0) begin
            top_next.pcs_mode = pcs_onehot(top_reg.pcs_sel);
        end

        if (wr_acc) begin
            case (paddr)
                PCS_SEL_ADDR: begin
                    if (pwdata[1:0] != 2'h3) begin
                        top_next.pcs_sel = pwdata[1:0];
                    end
                end
                DFE_ADDR: begin
                    for (int i = 0; i < LANES; i++) begin
                        top_next.dfe_cfg[i*DFE_FIELD_W +: DFE_FIELD_W] =
                            dfe_legal(pwdata[i*DFE_FIELD_W +: DFE_FIELD_W]);
                    end
                end
                CTLE_ADDR: begin
                    top_next.ctle_cfg = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // read data is prepared in the setup cycle: zero wait states
        top_next.ready = setup;
        top_next.err   = setup && !mapped(paddr);
        top_next.rdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (paddr)
                PCS_SEL_ADDR: top_next.rdata[1:0]  = top_reg.pcs_sel;
                DFE_ADDR:     top_next.rdata[7:0]  = top_reg.dfe_cfg;
                CTLE_ADDR:    top_next.rdata[15:0] = top_reg.ctle_cfg;
                STATUS_ADDR: begin
                    top_next.rdata[3:0] = lane_active;
                    top_next.rdata[STAT_BUSY_LSB +: LANES] = top_reg.busy_s;
                    top_next.rdata[STAT_RXEQ_LSB +: LANES] = top_reg.rxeq_s;
                    top_next.rdata[STAT_MIF_BIT] = top_reg.mif_s;
                end
                TRAINED_ADDR: begin
                    for (int i = 0; i < LANES; i++) begin
                        top_next.rdata[i*TRAINED_STRIDE] = top_reg.trained[i];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_reg <= '{busy_m: 4'h0, busy_s: 4'h0, rxeq_m: 4'h0, rxeq_s: 4'h0,
                         mif_m: 1'b0, mif_s: 1'b0, mif_d: 1'b0,
                         pcs_sel: PCS_SEL_RST, dfe_cfg: DFE_CFG_RST,
                         ctle_cfg: CTLE_CFG_RST, pcs_mode: PCS_AN, trained: 4'h0,
                         ctle_mode: 8'h00, rdata: 32'h0000_0000, ready: 1'b0,
                         err: 1'b0};
        end else begin
            top_reg <= top_next;
        end
    end

    assign prdata           = top_reg.rdata;
    assign pready           = top_reg.ready;
    assign pslverr          = top_reg.err;
    assign pcs_mode_request = top_reg.pcs_mode;
    assign linear_eq_mode   = top_reg.ctle_mode;
    assign custom_rxeq_en   = top_reg.trained;

    // ---------------------------------------------------------------
    // lanes
    // ---------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : gen_lane
        lane_reconf_ctrl u_lane (
            .pclk       (pclk),
            .presetn    (presetn),
            .launch     (launch_wr && pwdata[g]),
            .kind       (launch_kind),
            .abort      (abort),
            .dfe_in     (top_reg.dfe_cfg[g*DFE_FIELD_W +: DFE_FIELD_W]),
            .ctle_in    (top_reg.ctle_cfg[g*CTLE_FIELD_W +: CTLE_FIELD_W]),
            .busy       (top_reg.busy_s[g]),
            .pcs_go     (pcs_reconf_go[g]),
            .dfe_go     (decision_eq_go[g]),
            .ctle_go    (linear_eq_go[g]),
            .dfe_mode   (decision_eq_mode[g*DFE_FIELD_W +: DFE_FIELD_W]),
            .ctle_value (linear_eq_value[g*CTLE_FIELD_W +: CTLE_FIELD_W]),
            .active     (lane_active[g])
        );

        AST_GO_UNTIL_BUSY: assert property (
            (pcs_reconf_go[g] || decision_eq_go[g] || linear_eq_go[g]) &&
            !top_reg.busy_s[g] && !abort |=>
            (pcs_reconf_go[g] || decision_eq_go[g] || linear_eq_go[g]))
            else $error("start dropped before busy was seen");
        AST_NO_START_BUSY: assert property (
            $rose(pcs_reconf_go[g] | decision_eq_go[g] | linear_eq_go[g]) |->
            !$past(top_reg.busy_s[g]))
            else $error("start raised while lane busy");
        AST_DFE_STABLE: assert property (
            lane_active[g] && $past(lane_active[g]) |->
            $stable(decision_eq_mode[g*DFE_FIELD_W +: DFE_FIELD_W]))
            else $error("dfe mode changed during handshake");
        AST_CTLE_STABLE: assert property (
            lane_active[g] && $past(lane_active[g]) |->
            $stable(linear_eq_value[g*CTLE_FIELD_W +: CTLE_FIELD_W]))
            else $error("ctle value changed during handshake");
        AST_LANE_LAUNCH: assert property (
            launch_wr && pwdata[g] && launch_kind == KIND_DFE && !lane_active[g] &&
            !top_reg.busy_s[g] && !abort |=> decision_eq_go[g] ##0 lane_active[g])
            else $error("lane did not start on its own mask bit");
        AST_ONE_START: assert property (
            $onehot0({pcs_reconf_go[g], decision_eq_go[g], linear_eq_go[g]}))
            else $error("more than one start on a lane");
        AST_DFE_CODE: assert property (
            decision_eq_mode[g*DFE_FIELD_W + 1] == 1'b0)
            else $error("reserved dfe code driven");
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_PCS_ONEHOT: assert property (
        pcs_mode_request == PCS_AN || pcs_mode_request == PCS_LT ||
        pcs_mode_request == PCS_DATA)
        else $error("illegal pcs mode request");
    AST_CTLE_MODE_ZERO: assert property (
        ##1 linear_eq_mode == 8'h00)
        else $error("ctle mode not zero");
    AST_TRAINED_AND: assert property (
        (custom_rxeq_en & ~($past(rx_trained_lt) & $past(top_reg.rxeq_s))) == 4'h0)
        else $error("lane trained without both flags");
    AST_PCS_MODE_HOLD: assert property (
        $past(lane_active != 4'h0) |-> $stable(pcs_mode_request))
        else $error("pcs mode moved during handshake");
    AST_APB_READY: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not in access cycle");

    COV_PCS: cover property (
        $rose(pcs_reconf_go[0]) ##[1:40] $fell(pcs_reconf_go[0]));
    COV_DFE: cover property (
        $rose(decision_eq_go[1]) ##[1:40] !lane_active[1]);
    COV_CTLE: cover property (
        $rose(linear_eq_go[3]) ##[1:40] !lane_active[3]);
    COV_ABORT: cover property (abort && lane_active != 4'h0);

endmodule

//--- reconf_partner.sv
module reconf_partner
    import kr4_reconf_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // starts from the block
    input  wire logic [3:0] pcs_reconf_go,
    input  wire logic [3:0] decision_eq_go,
    input  wire logic [3:0] linear_eq_go,
    // bench controls
    input  wire logic [3:0] slow,
    input  wire logic [3:0] eq_req,
    // answers
    output logic      [3:0] reconf_in_progress,
    output logic      [3:0] rxeq_done
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------
    // per-lane job
    // ----------
    logic [3:0] req;
    int         cnt [4];

    assign req = pcs_reconf_go | decision_eq_go | linear_eq_go;

    // a start that drops before busy rises cancels the job, like an aborted request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reconf_in_progress <= 4'h0;
            rxeq_done <= 4'h0;
            for (int l = 0; l < 4; l++) cnt[l] <= 0;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (!reconf_in_progress[l]) begin
                    cnt[l] <= req[l] ? cnt[l] + 1 : 0;
                    if (req[l] && cnt[l] >= (slow[l] ? 30 : 2)) begin
                        reconf_in_progress[l] <= 1'b1;
                        cnt[l] <= 0;
                    end
                end else if (!req[l]) begin
                    cnt[l] <= cnt[l] + 1;
                    if (cnt[l] >= (slow[l] ? 12 : 1)) reconf_in_progress[l] <= 1'b0;
                end
                rxeq_done[l] <= eq_req[l];
            end
        end
    end
endmodule

//--- tb_top.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end

module tb_top
    import kr4_reconf_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // ----------
    // signals
    // ----------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        mif_done = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic [3:0]  busy, rxeq_done, pcs_go, dfe_go, ctle_go, rxeq_en, gos, m, lt, eq, e;
    logic [3:0]  rx_trained_lt = 4'h0, slow = 4'h0, eq_req = 4'h0;
    logic [3:0]  gos_q = 4'h0, trk = 4'h0, seen = 4'h0;
    logic [5:0]  pcs_mode;
    logic [7:0]  dfe_mode, ctle_mode, exp_dfe, d;
    logic [15:0] ctle_val, exp_ctle;
    logic [1:0]  hd [4];
    logic [3:0]  hc [4];
    logic [11:0] regs [6] = '{LAUNCH_ADDR, PCS_SEL_ADDR, DFE_ADDR, CTLE_ADDR, STATUS_ADDR,
                              TRAINED_ADDR};
    int          k;
    int          failures = 0;
    int          checked = 0;

    always #2.5 pclk = ~pclk;

    kr4_lane_reconf DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reconf_in_progress(busy), .rxeq_done(rxeq_done),
        .mif_done(mif_done), .rx_trained_lt(rx_trained_lt), .pcs_reconf_go(pcs_go),
        .pcs_mode_request(pcs_mode), .decision_eq_go(dfe_go), .decision_eq_mode(dfe_mode),
        .linear_eq_go(ctle_go), .linear_eq_value(ctle_val), .linear_eq_mode(ctle_mode),
        .custom_rxeq_en(rxeq_en));

    reconf_partner partner (.pclk(pclk), .presetn(presetn), .pcs_reconf_go(pcs_go),
        .decision_eq_go(dfe_go), .linear_eq_go(ctle_go), .slow(slow), .eq_req(eq_req),
        .reconf_in_progress(busy), .rxeq_done(rxeq_done));

    // ----------
    // helpers
    // ----------
    function automatic logic [5:0] exp_pcs(input int s);
        return (s == 0) ? 6'h01 : (s == 1) ? 6'h02 : 6'h20;
    endfunction

    function automatic logic [7:0] exp_dfe_of(input logic [7:0] v);
        for (int l = 0; l < 4; l++) exp_dfe_of[2*l +: 2] = (v[2*l +: 2] == 2'h1) ? 2'h1 : 2'h0;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dv,
                       output logic [31:0] r, output logic er);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= dv;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        er = pslverr;
        if (n >= 20) `CHK(pready, 1'b1)
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] dv);
        apb(1'b1, a, dv, rd, err);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] ev);
        apb(1'b0, a, 32'h0, rd, err);
        `CHK(rd, ev)
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, STATUS_ADDR, 32'h0, rd, err);
            n++;
        end while (rd[7:0] !== 8'h00 && n < 100);
        `CHK(rd[7:0], 8'h00)
    endtask

    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------
    // handshake monitor: fields latched at the start must hold until busy falls
    // ----------
    assign gos = pcs_go | dfe_go | ctle_go;
    always @(posedge pclk) begin
        for (int l = 0; l < 4; l++) begin
            if (presetn && gos[l] && !gos_q[l]) begin
                `CHK(busy[l], 1'b0)
                `CHK(ctle_mode, 8'h00)
                `CHK(dfe_mode[2*l+1], 1'b0)
                hd[l] = dfe_mode[2*l +: 2];
                hc[l] = ctle_val[4*l +: 4];
                if (dfe_go[l]) `CHK(hd[l], exp_dfe[2*l +: 2])
                if (ctle_go[l]) `CHK(hc[l], exp_ctle[4*l +: 4])
                trk[l] = 1'b1;
                seen[l] = 1'b0;
            end else if (trk[l]) begin
                seen[l] = seen[l] | busy[l];
                `CHK(dfe_mode[2*l +: 2], hd[l])
                `CHK(ctle_val[4*l +: 4], hc[l])
                if (!gos[l] && !seen[l] && !mif_done) `CHK(gos[l], 1'b1)
                if ((seen[l] && !busy[l]) || (!gos[l] && !seen[l])) trk[l] = 1'b0;
            end
        end
        gos_q = gos;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        test_done();
    end

    initial begin
        void'($urandom(15245));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(pcs_mode, 6'h01)
        `CHK({pcs_go, dfe_go, ctle_go, rxeq_en}, 16'h0000)
        `CHK({dfe_mode, ctle_mode, ctle_val}, 32'h0)
        foreach (regs[i]) rdc(regs[i], 32'h0);
        apb(1'b0, 12'h100, 32'h0, rd, err);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, 12'h104, 32'hFFFFFFFF, rd, err);
        `CHK(err, 1'b1)
        note("reset and map");
        for (int s = 0; s < 4; s++) begin
            wr(PCS_SEL_ADDR, 32'(s));
            repeat (2) @(posedge pclk);
            `CHK(pcs_mode, exp_pcs(s))
        end
        note("pcs mode");
        for (int it = 0; it < 12; it++) begin
            k = it % 4;
            m = 4'($urandom_range(15, 1));
            slow <= 4'($urandom);
            d = (it == 1) ? 8'hE4 : 8'($urandom);
            exp_dfe = exp_dfe_of(d);
            exp_ctle = (it == 3) ? 16'hFFFF : (it == 7) ? 16'h0000 : 16'($urandom);
            wr(DFE_ADDR, {24'h0, d});
            rdc(DFE_ADDR, {24'h0, exp_dfe});
            wr(CTLE_ADDR, {16'h0, exp_ctle});
            rdc(CTLE_ADDR, {16'h0, exp_ctle});
            wr(LAUNCH_ADDR, {26'h0, k[1:0], m});
            `CHK(pcs_go, (k == 1) ? m : 4'h0)
            `CHK(dfe_go, (k == 2) ? m : 4'h0)
            `CHK(ctle_go, (k == 3) ? m : 4'h0)
            wr(LAUNCH_ADDR, {26'h0, k[1:0], m});
            wait_idle();
        end
        note("launches");
        slow <= 4'hF;
        wr(LAUNCH_ADDR, 32'h2F);
        mif_done <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK(dfe_go, 4'h0)
        rdc(STATUS_ADDR, 32'h1000);
        mif_done <= 1'b0;
        slow <= 4'h0;
        note("abort");
        for (int it = 0; it < 6; it++) begin
            lt = (it == 0) ? 4'hF : 4'($urandom);
            eq = (it == 1) ? 4'hF : 4'($urandom);
            e = lt & eq;
            rx_trained_lt <= lt;
            eq_req <= eq;
            repeat (8) @(posedge pclk);
            `CHK(rxeq_en, e)
            rdc(TRAINED_ADDR, {7'h0, e[3], 7'h0, e[2], 7'h0, e[1], 7'h0, e[0]});
        end
        note("trained");
        test_done();
    end
endmodule
